// ### include/scan_arb_pkg.sv
package scan_arb_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFF      = 8'h00;
  localparam logic [7:0]  LOW_ADDR_OFF  = 8'h04;
  localparam logic [7:0]  HIGH_ADDR_OFF = 8'h08;
  localparam logic [7:0]  TRIG_OFF      = 8'h0C;
  localparam logic [7:0]  DISABLE_OFF   = 8'h10;

  // control field positions
  localparam int MODE_LSB      = 0;
  localparam int IRQ_PRIO_BIT  = 3;
  localparam int INVALID_BIT   = 4;
  localparam int BUSY_BIT      = 5;
  localparam int RUN_BIT       = 6;
  localparam int SCAN_EN_BIT   = 7;
  localparam int DONE_FLAG_BIT = 8;
  localparam int CRC_GO_BIT    = 9;
  localparam int CRC_EN_BIT    = 10;

  // disable register field positions
  localparam int CRC_DIS_BIT   = 0;
  localparam int SCAN_DIS_BIT  = 1;

  localparam int ADDR_W = 22;
  localparam int TSEL_W = 4;

  localparam logic [ADDR_W-1:0] ADDR_RST    = 22'h000000;
  localparam logic [ADDR_W-1:0] IMPL_LIMIT  = 22'h01FFFF;
  localparam logic [31:0]       SLVERR_DATA = 32'h00000000;

  typedef enum logic [1:0] {
    MODE_CONCURRENT = 2'h0,
    MODE_BURST      = 2'h1,
    MODE_PEEK       = 2'h2,
    MODE_TRIGGERED  = 2'h3
  } scan_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ARMED = 4'h2,
    ST_WAIT  = 4'h4,
    ST_READ  = 4'h8
  } scan_state_t;

endpackage : scan_arb_pkg

// ### logic/memory_scanner_mode_arbiter.sv
`timescale 1ns/1ps

module memory_scanner_mode_arbiter (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scanner_fuse_enable,
  input  wire logic [15:0] trigger_in,
  input  wire logic        cpu_needs_memory,
  input  wire logic        cpu_run_set,
  input  wire logic        irq_request,
  input  wire logic        irq_active,
  input  wire logic        debug_halt,
  input  wire logic        halt_before_scan,
  input  wire logic        data_bp_entry,
  output logic             cpu_stall,
  output logic             irq_hold,
  output logic [21:0]      mem_addr,
  output logic             mem_read,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        sum_ready,
  output logic [15:0]      sum_data,
  output logic             sum_valid,
  output logic             checksum_unit_disable,
  output logic             scanner_disabled
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                                   awready;
    logic                                   wready;
    logic                                   bvalid;
    logic [1:0]                             bresp;
    logic                                   rvalid;
    logic [31:0]                            rdata;
    logic [1:0]                             rresp;
    logic [7:0]                             awaddr;
    logic                                   aw_got;
    logic [31:0]                            wdata;
    logic                                   w_got;
    logic [1:0]                             mode;
    logic                                   prio;
    logic                                   scan_en;
    logic                                   run;
    logic                                   invalid;
    logic                                   done;
    logic                                   crc_en;
    logic                                   crc_go;
    logic                                   crc_dis;
    logic                                   scan_dis;
    logic [scan_arb_pkg::TSEL_W-1:0]        tsel;
    logic [scan_arb_pkg::ADDR_W-1:0]        low_addr;
    logic [scan_arb_pkg::ADDR_W-1:0]        high_addr;
    scan_arb_pkg::scan_state_t              st;
    logic                                   trig_prev;
    logic [15:0]                            word;
    logic                                   sum_valid;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic [15:0] trig_meta_r;
  logic [15:0] trig_sync_r;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_conc(input logic [1:0] m);
    is_conc = (m == scan_arb_pkg::MODE_CONCURRENT) || (m == scan_arb_pkg::MODE_TRIGGERED);
  endfunction : is_conc

  logic        unit_off;
  logic        paused;
  logic        may_access;
  logic        run_vis;
  logic        trig_now;
  logic        at_end;
  logic [31:0] ctrl_word;

  assign unit_off = !scanner_fuse_enable || (s_r.scan_dis && scanner_fuse_enable);
  assign scanner_disabled      = unit_off;
  assign checksum_unit_disable = s_r.crc_dis;
  assign trig_now = trig_sync_r[s_r.tsel];

  always_comb begin
    // interrupt pause in burst; in concurrent/triggered
    paused = s_r.prio && irq_active && (s_r.mode != scan_arb_pkg::MODE_PEEK);
    // debug freeze; burst suspended on halt
    if (debug_halt) begin
      paused = 1'b1;
    end
    // halt just before scan defers it; data bp postpones
    if (is_conc(s_r.mode) && (halt_before_scan || data_bp_entry)) begin
      paused = 1'b1;
    end
  end

  always_comb begin
    may_access = !paused && sum_ready;
    // peek uses only dead cycles; follows actual execution
    if (s_r.mode == scan_arb_pkg::MODE_PEEK) begin
      may_access = may_access && !cpu_needs_memory;
    end
  end

  assign run_vis = s_r.run && !(paused && s_r.prio && irq_active &&
                                (s_r.mode != scan_arb_pkg::MODE_PEEK));
  assign at_end  = (s_r.low_addr == s_r.high_addr) || (s_r.low_addr >= scan_arb_pkg::IMPL_LIMIT);

  always_comb begin
    ctrl_word = 32'h00000000;
    ctrl_word[scan_arb_pkg::MODE_LSB +: 2]     = s_r.mode;
    ctrl_word[scan_arb_pkg::IRQ_PRIO_BIT]      = s_r.prio;
    ctrl_word[scan_arb_pkg::INVALID_BIT]       = s_r.invalid;
    ctrl_word[scan_arb_pkg::BUSY_BIT]          = (s_r.st != scan_arb_pkg::ST_IDLE);
    ctrl_word[scan_arb_pkg::RUN_BIT]           = run_vis;
    ctrl_word[scan_arb_pkg::SCAN_EN_BIT]       = s_r.scan_en;
    ctrl_word[scan_arb_pkg::DONE_FLAG_BIT]     = s_r.done;
    ctrl_word[scan_arb_pkg::CRC_GO_BIT]        = s_r.crc_go;
    ctrl_word[scan_arb_pkg::CRC_EN_BIT]        = s_r.crc_en;
  end

  // ----------------------------------------------------------------
  // cpu side outputs
  // ----------------------------------------------------------------
  always_comb begin
    cpu_stall = 1'b0;
    irq_hold  = 1'b0;
    if (s_r.run && (s_r.mode == scan_arb_pkg::MODE_BURST) && !paused) begin
      // burst stall while busy; released at scan end or while paused
      cpu_stall = (s_r.st != scan_arb_pkg::ST_IDLE);
      irq_hold  = !s_r.prio && irq_request;
    end else if (is_conc(s_r.mode) && s_r.st == scan_arb_pkg::ST_READ) begin
      // stall only during the access; access completes
      cpu_stall = 1'b1;
    end
  end

  assign mem_addr  = s_r.low_addr;
  assign mem_read  = (s_r.st == scan_arb_pkg::ST_READ);
  assign sum_data  = s_r.word;
  assign sum_valid = s_r.sum_valid;
  // no watchdog interaction: nothing here feeds a watchdog clear

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] wd;
    wd      = 32'h00000000;
    s_nxt   = s_r;
    s_nxt.awready = 1'b0;
    s_nxt.wready  = 1'b0;
    s_nxt.trig_prev = trig_now;
    if (s_r.sum_valid && sum_ready) begin
      s_nxt.sum_valid = 1'b0;
    end
    // bus write
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.awaddr = s_axi_awaddr;
      s_nxt.aw_got = 1'b1;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.wdata = s_axi_wdata;
      s_nxt.w_got = 1'b1;
    end
    if (!s_r.aw_got && !s_r.awready && !s_r.bvalid && s_axi_awvalid) begin
      s_nxt.awready = 1'b1;
    end
    if (!s_r.w_got && !s_r.wready && !s_r.bvalid && s_axi_wvalid) begin
      s_nxt.wready = 1'b1;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = 2'h0;
      wd = s_r.wdata;
      case (s_r.awaddr)
        scan_arb_pkg::CTRL_OFF: begin
          s_nxt.mode    = wd[scan_arb_pkg::MODE_LSB +: 2];
          s_nxt.prio    = wd[scan_arb_pkg::IRQ_PRIO_BIT];
          s_nxt.scan_en = wd[scan_arb_pkg::SCAN_EN_BIT];
          s_nxt.crc_go  = wd[scan_arb_pkg::CRC_GO_BIT];
          s_nxt.crc_en  = wd[scan_arb_pkg::CRC_EN_BIT];
          if (!wd[scan_arb_pkg::INVALID_BIT]) begin
            s_nxt.invalid = 1'b0;
          end
          if (!wd[scan_arb_pkg::DONE_FLAG_BIT]) begin
            s_nxt.done = 1'b0;
          end
          if (!(s_r.run && s_r.mode == scan_arb_pkg::MODE_BURST)) begin
            s_nxt.run = wd[scan_arb_pkg::RUN_BIT] && !unit_off;
          end
        end
        scan_arb_pkg::LOW_ADDR_OFF:  s_nxt.low_addr  = wd[scan_arb_pkg::ADDR_W-1:0];
        scan_arb_pkg::HIGH_ADDR_OFF: s_nxt.high_addr = wd[scan_arb_pkg::ADDR_W-1:0];
        scan_arb_pkg::TRIG_OFF:      s_nxt.tsel      = wd[scan_arb_pkg::TSEL_W-1:0];
        scan_arb_pkg::DISABLE_OFF: begin
          s_nxt.crc_dis  = wd[scan_arb_pkg::CRC_DIS_BIT];
          s_nxt.scan_dis = wd[scan_arb_pkg::SCAN_DIS_BIT];
        end
        default: s_nxt.bresp = 2'h2;
      endcase
    end
    // bus read
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // scan engine
    case (s_r.st)
      scan_arb_pkg::ST_IDLE: begin
        if (s_r.run && s_r.scan_en && s_r.crc_go && !cpu_run_set && !debug_halt) begin
          // triggered waits; start deferred by debug
          s_nxt.st = (s_r.mode == scan_arb_pkg::MODE_TRIGGERED) ?
                     scan_arb_pkg::ST_ARMED : scan_arb_pkg::ST_WAIT;
        end
      end
      scan_arb_pkg::ST_ARMED: begin
        if (trig_now && !s_r.trig_prev) begin
          s_nxt.st = scan_arb_pkg::ST_WAIT;
        end
      end
      scan_arb_pkg::ST_WAIT: begin
        // only when checksum path can accept
        if (may_access && !s_r.sum_valid) begin
          s_nxt.st = scan_arb_pkg::ST_READ;
        end
      end
      scan_arb_pkg::ST_READ: begin
        s_nxt.word      = mem_rdata;
        s_nxt.sum_valid = 1'b1;
        if (at_end) begin
          s_nxt.st   = scan_arb_pkg::ST_IDLE;
          s_nxt.run  = 1'b0;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.low_addr = s_r.low_addr + 22'h000001;
          s_nxt.st = scan_arb_pkg::ST_WAIT;
        end
      end
      default: s_nxt.st = scan_arb_pkg::ST_IDLE;
    endcase
    if (!s_nxt.run && s_r.st != scan_arb_pkg::ST_READ) begin
      s_nxt.st = scan_arb_pkg::ST_IDLE;
    end
    // abort on enable or start cleared
    if (s_r.run && (!s_nxt.scan_en || !s_nxt.crc_go || !s_nxt.crc_en || unit_off)) begin
      s_nxt.run     = 1'b0;
      s_nxt.st      = scan_arb_pkg::ST_IDLE;
      s_nxt.invalid = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic        ar_rdy_r;
  assign s_axi_arready = ar_rdy_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ar_rdy_r <= 1'b0;
    end else begin
      ar_rdy_r <= s_axi_arvalid && !ar_rdy_r && !s_r.rvalid;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trig_meta_r <= 16'h0000;
      trig_sync_r <= 16'h0000;
    end else begin
      trig_meta_r <= trigger_in;
      trig_sync_r <= trig_meta_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r           <= '0;
      s_r.st        <= scan_arb_pkg::ST_IDLE;
      s_r.low_addr  <= scan_arb_pkg::ADDR_RST;
      s_r.high_addr <= scan_arb_pkg::ADDR_RST;
    end else begin
      s_r <= s_nxt;
      if (s_axi_arvalid && ar_rdy_r) begin
        s_r.rvalid <= 1'b1;
        s_r.rresp  <= 2'h0;
        case (s_axi_araddr)
          scan_arb_pkg::CTRL_OFF:      s_r.rdata <= ctrl_word;
          scan_arb_pkg::LOW_ADDR_OFF:  s_r.rdata <= {10'h000, s_r.low_addr};
          scan_arb_pkg::HIGH_ADDR_OFF: s_r.rdata <= {10'h000, s_r.high_addr};
          scan_arb_pkg::TRIG_OFF:      s_r.rdata <= {28'h0000000, s_r.tsel};
          scan_arb_pkg::DISABLE_OFF:   s_r.rdata <= {30'h00000000, s_r.scan_dis, s_r.crc_dis};
          default: begin
            s_r.rdata <= scan_arb_pkg::SLVERR_DATA;
            s_r.rresp <= 2'h2;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_end_sets_done: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.st == scan_arb_pkg::ST_READ && at_end && s_r.run && s_nxt.run == 1'b0 &&
     !s_r.invalid && s_nxt.invalid == 1'b0) |=> (s_r.done && !s_r.run))
    else $error("scan end did not set done");
  a_peek_no_stall: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.mode == scan_arb_pkg::MODE_PEEK) |-> !cpu_stall)
    else $error("peek mode stalled cpu");
  a_peek_dead_cycle: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.mode == scan_arb_pkg::MODE_PEEK && $rose(mem_read)) |-> !$past(cpu_needs_memory))
    else $error("peek read in busy cycle");
  a_abort_invalid: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.run && !s_nxt.scan_en) |=> (s_r.invalid && !s_r.run))
    else $error("abort did not flag invalid");
  a_halt_freeze: assert property (@(posedge ref_clk) disable iff (rst)
    (debug_halt && s_r.st == scan_arb_pkg::ST_WAIT) |=> s_r.st != scan_arb_pkg::ST_READ)
    else $error("scanner accessed during halt");
  a_sum_accept: assert property (@(posedge ref_clk) disable iff (rst)
    (sum_valid && !sum_ready) |=> (sum_valid && $stable(sum_data)))
    else $error("checksum word dropped");
  a_irq_hold: assert property (@(posedge ref_clk) disable iff (rst)
    irq_hold |-> (!s_r.prio && s_r.mode == scan_arb_pkg::MODE_BURST))
    else $error("interrupt held off wrongly");
  a_trig_wait: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.st == scan_arb_pkg::ST_ARMED && !(trig_now && !s_r.trig_prev)) |=>
      s_r.st != scan_arb_pkg::ST_WAIT || !s_r.run)
    else $error("triggered scan started without edge");

endmodule : memory_scanner_mode_arbiter

// ### test/flash_sum_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// flash array and checksum sink facing the scanner
// ----------------------------------------------------------------
module flash_sum_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic [21:0] mem_addr,
  input  wire logic        mem_read,
  output logic      [15:0] mem_rdata,
  output logic             sum_ready,
  input  wire logic [15:0] sum_data,
  input  wire logic        sum_valid,
  output int               words,
  output int               bad
);
  logic [15:0] held_r;
  logic [1:0]  div_r;
  logic [15:0] pend_q[$];

  // between reads the array shows the inverse of the last word
  assign mem_rdata = mem_read ? (mem_addr[15:0] ^ 16'h5A5A) : ~held_r;
  // a slow sink accepts one word in four cycles
  assign sum_ready = !rst && (!slow || div_r == 2'h3);

  always @(posedge ref_clk) begin
    div_r <= rst ? 2'h0 : div_r + 2'h1;
    if (rst) begin
      words <= 0;
      bad <= 0;
      held_r <= 16'h0000;
      pend_q.delete();
    end else begin
      if (mem_read) begin
        held_r <= mem_addr[15:0] ^ 16'h5A5A;
        pend_q.push_back(mem_addr[15:0] ^ 16'h5A5A);
      end
      if (sum_valid && sum_ready) begin
        words <= words + 1;
        if (pend_q.size() == 0 || sum_data !== pend_q.pop_front()) bad <= bad + 1;
      end
    end
  end
endmodule : flash_sum_model

// ### test/memory_scanner_mode_arbiter_tb.sv
`timescale 1ns/1ps

module memory_scanner_mode_arbiter_tb;
  logic        ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, fuse, need, irq, stall, ihold;
  logic        mrd, sready, svalid, cdis, sdis, slow, rset;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] trig, mdata, sdata;
  logic [21:0] maddr;
  logic [2:0]  hold;
  int          words, bad, b, base, s, cyc, stall_cnt, mismatches, n_checks;

  memory_scanner_mode_arbiter DUT (
    .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scanner_fuse_enable(fuse), .trigger_in(trig), .cpu_needs_memory(need),
    .cpu_run_set(rset), .irq_request(irq), .irq_active(irq), .debug_halt(hold[0]),
    .halt_before_scan(hold[1]), .data_bp_entry(hold[2]), .cpu_stall(stall),
    .irq_hold(ihold), .mem_addr(maddr), .mem_read(mrd), .mem_rdata(mdata),
    .sum_ready(sready), .sum_data(sdata), .sum_valid(svalid),
    .checksum_unit_disable(cdis), .scanner_disabled(sdis));

  flash_sum_model PARTNER (
    .ref_clk(ref_clk), .rst(rst), .slow(slow), .mem_addr(maddr), .mem_read(mrd),
    .mem_rdata(mdata), .sum_ready(sready), .sum_data(sdata), .sum_valid(svalid),
    .words(words), .bad(bad));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (stall === 1'b1) stall_cnt <= stall_cnt + 1;
    if (cyc == 60000) begin
      mismatches++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      // bready stays up between writes
      if (bvalid) break;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
  endtask : rd

  // enables on, then run set in a second write
  task automatic go(input int m, input int p, input logic [31:0] lo, input logic [31:0] hi);
    wr(8'h04, lo);
    wr(8'h08, hi);
    wr(8'h00, 32'h680 | m | (p << 3));
    base = words;
    wr(8'h00, 32'h6C0 | m | (p << 3));
  endtask : go

  task automatic fin(input int n);
    for (int k = 0; k < 600; k++) begin
      rd(8'h00);
      if (d[6] === 1'b0) break;
    end
    chk({d[8], d[6]}, 2'b10);
    // let a slow sink take the last word
    repeat (6) @(posedge ref_clk);
    chk(words - base, n);
  endtask : fin

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; fuse = 1'b1;
    need = 1'b0; irq = 1'b0; hold = 3'h0; trig = 16'h0000; slow = 1'b0; rset = 1'b0;
    cyc = 0; stall_cnt = 0; mismatches = 0; n_checks = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(8'h00);
    chk(d, 32'h0);
    rd(8'h14);
    chk({r, d}, {2'h2, 32'h0});
    go(0, 0, 16, 19);
    fin(4);
    go(0, 0, 32'h1FFFE, 32'h3FFFFF);
    fin(2);
    slow <= 1'b1;
    go(1, 0, 0, 63);
    repeat (8) begin
      @(posedge ref_clk);
      chk(stall, 1);
    end
    fin(64);
    for (int m = 0; m < 2; m++) begin
      go(m, 1, 0, 63);
      repeat (6) @(posedge ref_clk);
      irq <= 1'b1;
      repeat (6) @(posedge ref_clk);
      b = words;
      rd(8'h00);
      chk(d[6], 0);
      repeat (20) @(posedge ref_clk);
      chk(words - b, 0);
      chk(stall, 0);
      irq <= 1'b0;
      fin(64);
      go(m, 0, 0, 63);
      repeat (6) @(posedge ref_clk);
      irq <= 1'b1;
      b = words;
      repeat (30) @(posedge ref_clk);
      chk(words > b, 1);
      rd(8'h00);
      chk(d[6], 1);
      if (m == 1) chk(ihold, 1);
      irq <= 1'b0;
      fin(64);
    end
    wr(8'h0C, 32'h3);
    go(3, 0, 0, 3);
    repeat (20) @(posedge ref_clk);
    chk(words - base, 0);
    trig <= 16'h0008;
    repeat (4) @(posedge ref_clk);
    trig <= 16'h0000;
    fin(4);
    need <= 1'b1;
    s = stall_cnt;
    go(2, 1, 0, 3);
    repeat (20) @(posedge ref_clk);
    chk(words - base, 0);
    need <= 1'b0;
    irq <= 1'b1;
    fin(4);
    irq <= 1'b0;
    chk(stall_cnt - s, 0);
    rset <= 1'b1;
    go(1, 0, 0, 3);
    repeat (10) @(posedge ref_clk);
    chk(words - base, 0);
    chk(stall, 0);
    rset <= 1'b0;
    fin(4);
    for (int i = 0; i < 3; i++) begin
      go(0, 0, 0, 255);
      repeat (6) @(posedge ref_clk);
      hold <= 3'h1 << i;
      repeat (6) @(posedge ref_clk);
      b = words;
      repeat (20) @(posedge ref_clk);
      chk(words - b, 0);
      rd(8'h00);
      chk(d[7:6], 2'h3);
      hold <= 3'h0;
      wr(8'h00, 32'h600);
      rd(8'h00);
      chk({d[6], d[4]}, 2'b01);
    end
    fuse <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(sdis, 1);
    fuse <= 1'b1;
    wr(8'h10, 32'h2);
    repeat (3) @(posedge ref_clk);
    chk({cdis, sdis}, 2'b01);
    wr(8'h10, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk({cdis, sdis}, 2'b10);
    chk(bad, 0);
    summarize();
  end
endmodule : memory_scanner_mode_arbiter_tb
